// file: tb_top.sv
// testbench: register setup and tdm frames against the codec model
module tb_top
	import tdm_pair_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DLY = 3;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic sclk;
	logic fs;
	logic rx_a;
	logic tdv_out;
	logic tdv_oe_n;
	logic tx_a_out;
	logic tx_a_oe_n;
	logic sclk_oe_n;
	logic fs_oe_n;
	logic sclk_int;
	logic fs_int;
	logic [31:0] exp_q[$];
	logic [31:0] rx_word = 32'h0;
	logic [31:0] cap_word;
	logic [6:0] cap_slot;
	int cap_count;
	int fail_count = 0;
	int checked = 0;
	wire tx_wire = tx_a_oe_n ? 1'b1 : tx_a_out;
	wire tdv_wire = tdv_oe_n ? 1'b0 : tdv_out;

	always #20 clk_sys = ~clk_sys;

	tdm_pair u_tdm_pair (.clk_sys(clk_sys), .rst_n(rst_n), .ce(1'b1),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk_in(sclk), .sclk_out(sclk_int),
		.sclk_oe_n(sclk_oe_n), .fs_in(fs), .fs_out(fs_int),
		.fs_oe_n(fs_oe_n),
		.tdv_out(tdv_out), .tdv_oe_n(tdv_oe_n), .rx_a_in(rx_a),
		.rx_b_in(rx_a), .tx_a_out(tx_a_out), .tx_a_oe_n(tx_a_oe_n),
		.tx_b_out(), .tx_b_oe_n());

	tdm_codec_model #(.DLY(DLY)) u_tdm_codec_model (.sclk(sclk), .fs(fs),
		.rx_a(rx_a), .tx_a(tx_wire), .tdv(tdv_wire), .rx_word(rx_word),
		.cap_word(cap_word), .cap_slot(cap_slot), .cap_count(cap_count));

	task automatic report_and_stop();
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// called just after a rising edge; leaves one idle cycle behind
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			n++;
		end
		if (pready !== 1'b1) begin
			fail_count++;
			$display("mismatch at %0t: no bus answer", $time);
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
	endtask

	initial begin
		#400000;
		fail_count++;
		$display("mismatch at %0t: watchdog expired", $time);
		report_and_stop();
	end

	initial begin
		logic [31:0] r;
		logic [31:0] tx;
		logic [31:0] ctl;
		logic [31:0] mctl;
		logic err;
		logic prev;
		int n;
		void'($urandom(32'he922));
		rx_word = $urandom;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		apb(1'b0, CTL_OFS, 32'h0, r, err);
		chk(r, {19'h0, CTL_RST});
		apb(1'b0, DIV_OFS, 32'h0, r, err);
		chk(r, {24'h0, DIV_RST});
		apb(1'b0, 8'h60, 32'h0, r, err);
		chk({31'h0, err}, 32'h1);
		// slot 2 leaves through word 0 bit 2, slot 1 is taken in
		apb(1'b1, {TXSEL_GRP, 4'h0}, 32'h4, r, err);
		apb(1'b1, {RXSEL_GRP, 4'h0}, 32'h2, r, err);
		ctl = 32'h1 | (1 << EDGE_B) | (1 << LEVEL_B) | (7 << WLEN_LSB);
		apb(1'b1, CTL_OFS, ctl, r, err);
		mctl = 32'h1 | (DLY << MFD_LSB) | (3 << NCH_LSB);
		apb(1'b1, MCTL_OFS, mctl, r, err);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, tdv_oe_n}, 32'h0);
		chk({30'h0, sclk_oe_n, fs_oe_n}, 32'h3);
		for (int f = 0; f < 4; f++) begin
			tx = $urandom;
			apb(1'b1, TXA_OFS, tx, r, err);
			exp_q.push_back({24'h0, tx[7:0]});
			n = cap_count;
			repeat (3000) if (cap_count == n) @(posedge clk_sys);
			chk(32'(cap_count != n), 32'h1);
			chk(cap_word, exp_q.pop_front());
			chk({25'h0, cap_slot}, 32'h2);
			apb(1'b0, RXA_OFS, 32'h0, r, err);
			chk(r, {24'h0, rx_word[7:0]});
			apb(1'b0, MCTL_OFS, 32'h0, r, err);
			chk({31'h0, r[22:16] <= 7'h3}, 32'h1);
			rx_word = $urandom;
		end
		apb(1'b1, MCTL_OFS, 32'h1 << MSE_B_B, r, err);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, tdv_oe_n}, 32'h0);
		apb(1'b1, MCTL_OFS, 32'h0, r, err);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, tdv_oe_n}, 32'h1);
		ctl = ctl | (1 << INT_CLK_B) | (1 << INT_FS_B);
		apb(1'b1, CTL_OFS, ctl, r, err);
		apb(1'b1, MCTL_OFS, mctl, r, err);
		repeat (2) @(posedge clk_sys);
		chk({30'h0, sclk_oe_n, fs_oe_n}, 32'h0);
		// internal clock toggles once every DIV+1 system cycles
		n = 0;
		prev = sclk_int;
		repeat (40) begin
			@(posedge clk_sys);
			n += (sclk_int !== prev);
			prev = sclk_int;
		end
		chk(32'(n), 32'(40 / (DIV_RST + 8'h01)));
		// internal sync: one pulse per 4 slots of 8 bits
		n = 0;
		prev = fs_int;
		repeat (256) begin
			@(posedge clk_sys);
			n += (fs_int && !prev);
			prev = fs_int;
		end
		chk(32'(n), 32'(256 / (64 * (DIV_RST + 8'h01))));
		report_and_stop();
	end
endmodule

// file: tdm_codec_model.sv
// far-side codec model: serial clock, frame sync, receive lane, capture
module tdm_codec_model #(
	parameter int WL = 8,
	parameter int NSLOT = 4,
	parameter int DLY = 3,
	parameter int RX_SLOT = 1
) (
	output logic sclk,
	output logic fs,
	output logic rx_a,
	input wire logic tx_a,
	input wire logic tdv,
	input wire logic [31:0] rx_word,
	output logic [31:0] cap_word,
	output logic [6:0] cap_slot,
	output int cap_count
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int F = WL * NSLOT;
	int e;
	int p;
	logic [31:0] cur;
	logic [31:0] acc;
	logic busy;
	initial begin
		sclk = 1'b0;
		fs = 1'b0;
		rx_a = 1'b0;
		cap_word = 32'h0;
		cap_slot = 7'h0;
		cap_count = 0;
		cur = 32'h0;
		acc = 32'h0;
		busy = 1'b0;
		e = F;
		#7;
		forever begin
			// look at the bit just past before driving the next one;
			// the unit sees our edges several system cycles late
			if (tdv) begin
				if (!busy) begin
					cap_slot = 7'(((e - 1 - DLY) % F) / WL);
				end
				acc = {acc[30:0], tx_a};
				busy = 1'b1;
			end else if (busy) begin
				cap_word = acc;
				acc = 32'h0;
				busy = 1'b0;
				cap_count++;
			end
			p = (e - DLY) % F;
			if (p == 0) begin
				cur = rx_word;
			end
			fs = (e % F == 0);
			// other slots toggle so stale data never looks valid
			rx_a = (p / WL == RX_SLOT) ? cur[WL - 1 - p % WL] : ~rx_a;
			e++;
			#160 sclk = 1'b1;
			#160 sclk = 1'b0;
		end
	end
endmodule

// file: tdm_pair.sv
// paired multislot serial unit: transmit and receive halves, APB registers
//
// The APB register port and the address map were chosen for this implementation.
module tdm_pair
	import tdm_pair_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe_n,
	input wire logic fs_in,
	output logic fs_out,
	output logic fs_oe_n,
	output logic tdv_out,
	output logic tdv_oe_n,
	input wire logic rx_a_in,
	input wire logic rx_b_in,
	output logic tx_a_out,
	output logic tx_a_oe_n,
	output logic tx_b_out,
	output logic tx_b_oe_n
);
	function automatic logic [7:0] compress(input logic [15:0] x,
		input logic alaw);
		logic s;
		logic [15:0] m;
		logic [15:0] t;
		logic [2:0] e;
		s = x[15];
		m = s ? ~x : x;
		e = 3'h0;
		if (!alaw) begin
			if (m > MU_CLIP)
				m = MU_CLIP;
			m = m + MU_BIAS;
			for (int i = 1; i < 8; i++)
				if (m[i+7])
					e = 3'(i);
			t = m >> ({2'h0, e} + 5'h03);
			return ~{s, e, t[3:0]};
		end
		m = m >> 3;
		for (int i = 1; i < 8; i++)
			if (m[i+4])
				e = 3'(i);
		t = (e == 3'h0) ? (m >> 1) : (m >> e);
		return {~s, e, t[3:0]} ^ A_XOR;
	endfunction

	function automatic logic [15:0] expand(input logic [7:0] c,
		input logic alaw);
		logic [7:0] v;
		logic [15:0] m;
		if (!alaw) begin
			v = ~c;
			m = ((({12'h000, v[3:0]} << 3) + MU_BIAS) << v[6:4]) - MU_BIAS;
			return v[7] ? -m : m;
		end
		v = c ^ A_XOR;
		if (v[6:4] == 3'h0)
			m = {8'h00, v[3:0], 4'h8};
		else
			m = ({8'h00, v[3:0], 4'h0} + A_SEG_OFS) << (v[6:4] - 3'h1);
		return v[7] ? m : -m;
	endfunction

	logic [CTL_W-1:0] ctl;
	logic mse_a, mse_b;
	logic [3:0] frame_to_data_delay;
	logic [6:0] slot_count_minus_one;
	logic [7:0] divr;
	logic [31:0] txa, txb, rxa, rxb;
	logic txa_full, txb_full, rxa_full, rxb_full;
	logic [127:0] txsel, rxsel, txcmp, rxcmp;
	logic sclk_s1, sclk_s2, sclk_s3, fs_s1, fs_s2;
	logic rxa_s1, rxa_s2, rxb_s1, rxb_s2;
	logic [7:0] dcnt;
	logic [13:0] fcnt;
	logic fs_gen;
	frame_st_t st;
	logic [3:0] dly;
	logic [6:0] slot;
	logic [4:0] bitn;
	logic [31:0] rsa, rsb, twa, twb;
	logic armed, tv;

	// format bit must be zero; either enable starts the pair
	logic mc_on;
	assign mc_on = (mse_a | mse_b) & ~ctl[OPFMT_B];
	logic int_clk, int_fs, edge_sel, lvl, law, en_a, en_b;
	assign int_clk = ctl[INT_CLK_B];
	assign int_fs = ctl[INT_FS_B];
	assign edge_sel = ctl[EDGE_B];
	assign lvl = ctl[LEVEL_B];
	assign law = ctl[LAW_B];
	assign en_a = ctl[LANE_A_EN_B];
	assign en_b = ctl[LANE_B_EN_B];
	logic [4:0] wl;
	// word length field holds bits minus one; below 3 bits is clamped
	assign wl = (ctl[WLEN_LSB+:5] < WLEN_MIN) ? WLEN_MIN
		: ctl[WLEN_LSB+:5];

	// apb: one wait-free access phase, ready registered from setup
	logic acc, wr, rd, hit;
	logic [31:0] rdata;
	logic [1:0] widx;
	assign acc = psel & penable & pready;
	assign wr = acc & pwrite;
	assign rd = acc & ~pwrite;
	assign widx = paddr[3:2];
	always_comb begin
		hit = 1'b1;
		rdata = 32'h0000_0000;
		case (paddr[7:4])
			TXSEL_GRP: rdata = txsel[{widx, 5'h00}+:32];
			RXSEL_GRP: rdata = rxsel[{widx, 5'h00}+:32];
			TXCMP_GRP: rdata = txcmp[{widx, 5'h00}+:32];
			RXCMP_GRP: rdata = rxcmp[{widx, 5'h00}+:32];
			default: begin
				case (paddr)
					CTL_OFS: rdata = {19'h0, ctl};
					MCTL_OFS: rdata = {9'h0, slot, 3'h0, mse_b, slot_count_minus_one, frame_to_data_delay,
						mse_a};
					DIV_OFS: rdata = {24'h0, divr};
					TXA_OFS: rdata = txa;
					TXB_OFS: rdata = txb;
					RXA_OFS: rdata = rxa;
					RXB_OFS: rdata = rxb;
					STAT_OFS: rdata = {24'h0, st, armed, rxb_full, rxa_full,
						txb_full, txa_full};
					default: hit = 1'b0;
				endcase
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready <= psel & ~penable;
			prdata <= (psel & ~penable & ~pwrite) ? rdata : 32'h0000_0000;
			pslverr <= psel & ~penable & ~hit;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ctl <= CTL_RST;
			mse_a <= 1'b0;
			mse_b <= 1'b0;
			frame_to_data_delay <= 4'h0;
			slot_count_minus_one <= 7'h00;
			divr <= DIV_RST;
			txsel <= '0;
			rxsel <= '0;
			txcmp <= '0;
			rxcmp <= '0;
		end else if (ce && wr) begin
			case (paddr[7:4])
				TXSEL_GRP: txsel[{widx, 5'h00}+:32] <= pwdata;
				RXSEL_GRP: rxsel[{widx, 5'h00}+:32] <= pwdata;
				TXCMP_GRP: txcmp[{widx, 5'h00}+:32] <= pwdata;
				RXCMP_GRP: rxcmp[{widx, 5'h00}+:32] <= pwdata;
				default: begin
					if (paddr == CTL_OFS)
						ctl <= pwdata[CTL_W-1:0];
					if (paddr == MCTL_OFS) begin
						mse_a <= pwdata[MSE_A_B];
						mse_b <= pwdata[MSE_B_B];
						frame_to_data_delay <= pwdata[MFD_LSB+:4];
						slot_count_minus_one <= pwdata[NCH_LSB+:7];
					end
					if (paddr == DIV_OFS)
						divr <= pwdata[7:0];
				end
			endcase
		end
	end

	// pins from the bus are brought in through two flops each; the serial clock gets a third for finding its edges
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			{sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
			{fs_s1, fs_s2, rxa_s1, rxa_s2, rxb_s1, rxb_s2} <= 6'h00;
		end else if (ce) begin
			sclk_s1 <= sclk_in;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			fs_s1 <= fs_in;
			fs_s2 <= fs_s1;
			rxa_s1 <= rx_a_in;
			rxa_s2 <= rxa_s1;
			rxb_s1 <= rx_b_in;
			rxb_s2 <= rxb_s1;
		end
	end

	// one serial clock drives both halves; no separate receive clock
	logic tick, rise, fall, samp, drv;
	assign tick = mc_on & int_clk & (dcnt == divr);
	assign rise = int_clk ? (tick & ~sclk_out)
		: (sclk_s2 & ~sclk_s3);
	assign fall = int_clk ? (tick & sclk_out) : (~sclk_s2 & sclk_s3);
	assign samp = mc_on & (edge_sel ? rise : fall);
	assign drv = mc_on & (edge_sel ? fall : rise);

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dcnt <= 8'h00;
			sclk_out <= 1'b0;
			sclk_oe_n <= 1'b1;
		end else if (ce) begin
			dcnt <= (tick || !mc_on || !int_clk) ? 8'h00 : dcnt + 8'h01;
			if (tick)
				sclk_out <= ~sclk_out;
			sclk_oe_n <= ~(mc_on & int_clk);
		end
	end

	// internal frame sync: one serial clock wide, once per frame
	logic [13:0] flen;
	assign flen = 14'({7'h00, slot_count_minus_one} + 14'h0001) * 14'({9'h000, wl} + 14'h0001);
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fcnt <= 14'h0000;
			fs_gen <= 1'b0;
			fs_out <= 1'b0;
			fs_oe_n <= 1'b1;
		end else if (ce) begin
			if (!mc_on || !int_fs) begin
				fcnt <= 14'h0000;
				fs_gen <= 1'b0;
			end else if (drv) begin
				fs_gen <= (fcnt == 14'h0000);
				fcnt <= (fcnt >= flen - 14'h0001) ? 14'h0000
					: fcnt + 14'h0001;
			end
			fs_out <= fs_gen ? lvl : ~lvl;
			fs_oe_n <= ~(mc_on & int_fs);
		end
	end

	// the receive unit's sync, own or external, frames both halves
	logic fs_hit;
	assign fs_hit = samp & (int_fs ? fs_gen : (fs_s2 == lvl));

	// position being processed at this sample edge
	logic u_go, f_start;
	logic [6:0] u_slot;
	logic [4:0] u_bit;
	// slot 0 bit 0: the sync edge itself, or the edge ending the delay
	assign f_start = samp
		& (fs_hit ? (frame_to_data_delay == 4'h0) : (dly == 4'h1));
	always_comb begin
		u_go = 1'b0;
		u_slot = slot;
		u_bit = bitn;
		if (f_start) begin
			u_go = 1'b1;
			u_slot = 7'h00;
			u_bit = 5'h00;
		end else if (samp) begin
			// old frame runs on while a new sync is delayed
			u_go = (st == ST_RUN);
		end
	end

	// a sync mid frame simply restarts; frames run back to back
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st <= ST_IDLE;
			dly <= 4'h0;
			slot <= 7'h00;
			bitn <= 5'h00;
		end else if (ce) begin
			case (st)
				ST_IDLE: if (mc_on)
					st <= ST_WAIT;
				ST_WAIT: if (!mc_on)
					st <= ST_IDLE;
				else if (f_start)
					st <= ST_RUN;
				ST_RUN: if (!mc_on)
					st <= ST_IDLE;
				default: st <= ST_IDLE;
			endcase
			if (!mc_on) begin
				dly <= 4'h0;
				slot <= 7'h00;
				bitn <= 5'h00;
			end else begin
				if (fs_hit)
					dly <= frame_to_data_delay;
				else if (samp && dly != 4'h0)
					dly <= dly - 4'h1;
				if (u_go) begin
					if (u_bit == wl) begin
						bitn <= 5'h00;
						slot <= (u_slot == slot_count_minus_one) ? 7'h00
							: u_slot + 7'h01;
					end else begin
						bitn <= u_bit + 5'h01;
						slot <= u_slot;
					end
				end
			end
		end
	end

	// receive half: only stores selected slots, nothing else checked
	logic [31:0] rna, rnb;
	assign rna = {(u_bit == 5'h00) ? 31'h0 : rsa[30:0], rxa_s2};
	assign rnb = {(u_bit == 5'h00) ? 31'h0 : rsb[30:0], rxb_s2};
	logic rx_last;
	assign rx_last = u_go & (u_bit == wl) & rxsel[u_slot];
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsa <= 32'h0000_0000;
			rsb <= 32'h0000_0000;
			rxa <= 32'h0000_0000;
			rxb <= 32'h0000_0000;
			rxa_full <= 1'b0;
			rxb_full <= 1'b0;
		end else if (ce) begin
			if (u_go) begin
				rsa <= rna;
				rsb <= rnb;
			end
			if (rd && paddr == RXA_OFS)
				rxa_full <= 1'b0;
			if (rd && paddr == RXB_OFS)
				rxb_full <= 1'b0;
			// new word beats a read in the same cycle
			if (rx_last && en_a) begin
				rxa <= rxcmp[u_slot] ? {16'h0, expand(rna[7:0], law)}
					: rna;
				rxa_full <= 1'b1;
			end
			if (rx_last && en_b) begin
				rxb <= rnb;
				rxb_full <= 1'b1;
			end
		end
	end

	// transmit half: the position for the next sample edge
	logic p_ok, p_load, take;
	logic [6:0] p_slot;
	logic [4:0] p_bit;
	logic [31:0] cwa, cwb;
	assign p_ok = (dly == 4'h1) || (st == ST_RUN);
	assign p_slot = (dly == 4'h1) ? 7'h00 : slot;
	assign p_bit = (dly == 4'h1) ? 5'h00 : bitn;
	assign p_load = drv & p_ok & (p_bit == 5'h00);
	assign take = p_load & armed & txsel[p_slot];
	assign cwa = txcmp[p_slot] ? {24'h0, compress(txa[15:0], law)}
		: txa;
	assign cwb = txb;

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			armed <= 1'b0;
		end else if (ce) begin
			if (!mc_on)
				armed <= 1'b0;
			else if (txa_full)
				armed <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			txa <= 32'h0000_0000;
			txb <= 32'h0000_0000;
			txa_full <= 1'b0;
			txb_full <= 1'b0;
		end else if (ce) begin
			if (take && en_a)
				txa_full <= 1'b0;
			if (take && en_b)
				txb_full <= 1'b0;
			// a software load beats a take in the same cycle
			if (wr && paddr == TXA_OFS) begin
				txa <= pwdata;
				txa_full <= 1'b1;
			end
			if (wr && paddr == TXB_OFS) begin
				txb <= pwdata;
				txb_full <= 1'b1;
			end
		end
	end

	// data lanes drive only in selected slots; valid follows them
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			tv <= 1'b0;
			twa <= 32'h0000_0000;
			twb <= 32'h0000_0000;
			tx_a_out <= 1'b0;
			tx_b_out <= 1'b0;
			tx_a_oe_n <= 1'b1;
			tx_b_oe_n <= 1'b1;
			tdv_out <= 1'b0;
			tdv_oe_n <= 1'b1;
		end else if (ce) begin
			if (!mc_on) begin
				tv <= 1'b0;
			end else if (drv) begin
				if (!p_ok)
					tv <= 1'b0;
				else if (p_load)
					tv <= take;
			end
			if (p_load) begin
				twa <= cwa;
				twb <= cwb;
			end
			if (drv && p_ok) begin
				tx_a_out <= p_load ? cwa[wl] : twa[wl-p_bit];
				tx_b_out <= p_load ? cwb[wl] : twb[wl-p_bit];
			end
			tx_a_oe_n <= ~(tv & en_a);
			tx_b_oe_n <= ~(tv & en_b);
			tdv_out <= (tv & armed) ? lvl : ~lvl;
			tdv_oe_n <= ~mc_on;
		end
	end

	sequence sync_seen;
		ce && fs_hit && frame_to_data_delay != 4'h0;
	endsequence
	sequence delay_loaded;
		ce && dly == $past(frame_to_data_delay);
	endsequence

	property delay_start_p;
		@(posedge clk_sys) disable iff (!rst_n)
		sync_seen |=> delay_loaded;
	endproperty
	frame_delay_a: assert property (delay_start_p)
		else $error("delay not loaded from field at frame sync");

	zero_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && fs_hit && frame_to_data_delay == 4'h0 |=> slot == 7'h00 && bitn == 5'h01
	)
		else $error("zero delay did not start slot 0 bit 0");

	slot_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && u_go && u_bit == wl && u_slot == slot_count_minus_one |=> slot == 7'h00
	)
		else $error("slot did not wrap at programmed count");

	delay_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && samp && !fs_hit && dly == 4'h1 |=> slot == 7'h00 && dly == 4'h0
	)
		else $error("slot not zero after delay");

	rx_discard_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && en_a && !rxa_full && u_go && u_bit == wl && !rxsel[u_slot]
		|=> !rxa_full
	)
		else $error("unselected slot reached receive buffer");

	drive_valid_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!tx_a_oe_n |-> $past(tv) && $past(en_a)
	)
		else $error("lane driven outside a selected slot");

	no_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !armed && !txa_full ##1 ce |=> tdv_out == !$past(lvl)
	)
		else $error("data valid before buffer loaded");

	mc_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		ce && !mc_on |=> tdv_oe_n && sclk_oe_n && fs_oe_n
	)
		else $error("pins driven with multislot off");

	clk_master_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!sclk_oe_n |-> $past(int_clk)
	)
		else $error("clock driven while not master");
endmodule

// file: tdm_pair_pkg.sv
// constants for the paired multislot serial unit
package tdm_pair_pkg;
	// register byte offsets
	localparam logic [7:0] CTL_OFS = 8'h00;
	localparam logic [7:0] MCTL_OFS = 8'h04;
	localparam logic [7:0] DIV_OFS = 8'h08;
	localparam logic [7:0] TXA_OFS = 8'h0c;
	localparam logic [7:0] TXB_OFS = 8'h10;
	localparam logic [7:0] RXA_OFS = 8'h14;
	localparam logic [7:0] RXB_OFS = 8'h18;
	localparam logic [7:0] STAT_OFS = 8'h1c;
	// four-word groups, selected by address bits 7:4
	localparam logic [3:0] TXSEL_GRP = 4'h2;
	localparam logic [3:0] RXSEL_GRP = 4'h3;
	localparam logic [3:0] TXCMP_GRP = 4'h4;
	localparam logic [3:0] RXCMP_GRP = 4'h5;
	// serial_control_reg fields
	localparam int LANE_A_EN_B = 0;
	localparam int LANE_B_EN_B = 1;
	localparam int OPFMT_B = 2;
	localparam int INT_CLK_B = 3;
	localparam int EDGE_B = 4;
	localparam int INT_FS_B = 5;
	localparam int LEVEL_B = 6;
	localparam int WLEN_LSB = 7;
	localparam int LAW_B = 12;
	localparam int CTL_W = 13;
	// multislot_control_reg fields
	localparam int MSE_A_B = 0;
	localparam int MFD_LSB = 1;
	localparam int NCH_LSB = 5;
	localparam int MSE_B_B = 12;
	localparam int SLOT_LSB = 16;
	// reset values and minimum word length field
	localparam logic [CTL_W-1:0] CTL_RST = 13'h0f80;
	localparam logic [7:0] DIV_RST = 8'h01;
	localparam logic [4:0] WLEN_MIN = 5'h02;
	// companding constants
	localparam logic [15:0] MU_BIAS = 16'h0084;
	localparam logic [15:0] MU_CLIP = 16'h7f7b;
	localparam logic [15:0] A_SEG_OFS = 16'h0108;
	localparam logic [7:0] A_XOR = 8'h55;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN = 3'b100
	} frame_st_t;
endpackage
